// ### src/gpb_port_bank.sv
// low port bank: ports 0..2 with apb register access
`timescale 1ns/1ps

module gpb_port_bank
  import gpb_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [GPB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              osc_fail_reset,
  input  wire logic              stop_mode,
  input  wire logic [3:0]        port0_pin_in,
  output logic      [3:0]        port0_pin_out,
  output logic      [3:0]        port0_pin_oe,
  output logic      [3:0]        port0_periph_in,
  input  wire logic [7:0]        port1_pin_in,
  output logic      [7:0]        port1_pin_out,
  output logic      [7:0]        port1_pin_oe,
  output logic      [7:0]        port1_periph_in,
  input  wire logic [2:0]        port2_bit0_stop_pin_in,
  output logic      [2:0]        port2_pin_out,
  output logic      [2:0]        port2_pin_oe,
  output logic      [2:0]        port2_fall_edge
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gpb_state_t st;       // all registered state
  gpb_state_t next_st;  // next value of the state
  logic       setup;    // apb setup cycle
  logic       commit;   // access edge with pready high
  // 8-bit copies hold the results of the shared truth table helpers
  logic [7:0] p0_view;  // port0 read view, zero extended
  logic [7:0] p1_view;  // port1 read view
  logic [7:0] p0_oe8;   // port0 enable, zero extended
  logic [7:0] p1_oe8;   // port1 enable

  // request and commit strobes
  assign setup  = psel & ~penable;
  assign commit = psel & penable & st.pready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    // read and peripheral views, from the pins of this cycle
    p0_view  = gpb_view({4'h0, st.p0_od}, {4'h0, st.p0_dir}, {4'h0, st.p0_lat},
                        {4'h0, port0_pin_in});
    p1_view  = gpb_view(st.p1_od, st.p1_dir, st.p1_lat, port1_pin_in);
    // apb phases
    unique case (st.bus_st)
      BUS_IDLE: begin
        // pins are sampled here, in the first state of the read
        if (setup) begin
          next_st.bus_st  = BUS_RESP;
          next_st.pready  = 1'b1;
          next_st.pslverr = 1'b0;
          next_st.prdata  = 32'h0;
          // decode the read; prdata holds it until the next transfer, pready stands for one cycle
          unique case (paddr)
            OFF_P0_DATA: next_st.prdata[7:0] = p0_view;
            OFF_P0_LATV: next_st.prdata[3:0] = st.p0_lat;
            OFF_P0_DIR:  next_st.prdata[3:0] = st.p0_dir;
            OFF_P0_OD:   next_st.prdata[3:0] = st.p0_od;
            OFF_P1_DATA: next_st.prdata[7:0] = p1_view;
            OFF_P1_LATV: next_st.prdata[7:0] = st.p1_lat;
            OFF_P1_DIR:  next_st.prdata[7:0] = st.p1_dir;
            OFF_P1_OD:   next_st.prdata[7:0] = st.p1_od;
            // upper bits of the third port read as zero
            OFF_P2_DATA: next_st.prdata[2:0] = port2_bit0_stop_pin_in;
            OFF_P2_LATV: next_st.prdata[2:0] = st.p2_lat;
            OFF_SYSCTL:  next_st.prdata[BIT_HOLD_EN] = st.hold_en;
            // status reports the live stop and oscillator inputs
            OFF_STATUS: begin
              next_st.prdata[BIT_ST_STOP]  = stop_mode;
              next_st.prdata[BIT_ST_OFAIL] = osc_fail_reset;
            end
            default:     next_st.pslverr = 1'b1;  // unmapped address
          endcase
        end
      end
      BUS_RESP: begin
        // write lands at the access edge, second state of the cycle
        next_st.bus_st  = BUS_IDLE;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        // a write to a read-only or unmapped word changes nothing
        if (commit && pwrite && !st.pslverr) begin
          unique case (paddr)
            OFF_P0_DATA, OFF_P0_LATV: next_st.p0_lat = pwdata[3:0];
            OFF_P0_DIR:               next_st.p0_dir = pwdata[3:0];
            OFF_P0_OD:                next_st.p0_od  = pwdata[3:0];
            OFF_P1_DATA, OFF_P1_LATV: next_st.p1_lat = pwdata[7:0];
            OFF_P1_DIR:               next_st.p1_dir = pwdata[7:0];
            OFF_P1_OD:                next_st.p1_od  = pwdata[7:0];
            OFF_P2_DATA, OFF_P2_LATV: next_st.p2_lat = pwdata[2:0];
            OFF_SYSCTL:               next_st.hold_en = pwdata[BIT_HOLD_EN];
            default:                  next_st.p0_lat = st.p0_lat;   // read-only or unmapped
          endcase
        end
      end
    endcase
    // oscillator failure acts as a synchronous reset of the controls
    if (osc_fail_reset) begin
      next_st.p0_dir  = RST_P0;
      next_st.p0_od   = RST_P0;
      next_st.p0_lat  = RST_P0;
      next_st.p1_dir  = RST_P1;
      next_st.p1_od   = RST_P1;
      next_st.p1_lat  = RST_P1;
      next_st.p2_lat  = RST_P2;
      next_st.hold_en = RST_HOLD;
    end
    // pin drive from the new control values
    p0_oe8 = gpb_oe({4'h0, next_st.p0_od}, {4'h0, next_st.p0_dir}, {4'h0, next_st.p0_lat});
    p1_oe8 = gpb_oe(next_st.p1_od, next_st.p1_dir, next_st.p1_lat);
    // port0 and port1 share one truth table
    next_st.p0_oe  = p0_oe8[3:0];
    next_st.p0_out = next_st.p0_lat & ~next_st.p0_od;
    next_st.p1_oe  = p1_oe8;
    next_st.p1_out = next_st.p1_lat & ~next_st.p1_od;
    // third port: latch low pulls low, latch high releases
    next_st.p2_oe  = ~next_st.p2_lat;
    // the third port never drives a pin high
    next_st.p2_out = 3'h0;
    // stop mode without hold floats everything
    if (stop_mode && !next_st.hold_en) begin
      next_st.p0_oe = 4'h0;
      next_st.p1_oe = 8'h00;
      next_st.p2_oe = 3'h0;
    end
    // stop pin always floats in stop mode
    if (stop_mode) begin
      next_st.p2_oe[0] = 1'b0;
    end
    // failing oscillator floats every pin
    if (osc_fail_reset) begin
      next_st.p0_oe = 4'h0;
      next_st.p1_oe = 8'h00;
      next_st.p2_oe = 3'h0;
    end
    // peripheral view follows the same table as reads
    next_st.p0_per = p0_view[3:0];
    next_st.p1_per = p1_view;
    // falling pin edge feeds the external interrupt latch
    // a pin seen high then low gives a one-cycle pulse
    next_st.p2_pin_q = port2_bit0_stop_pin_in;
    next_st.p2_edge  = st.p2_pin_q & ~port2_bit0_stop_pin_in;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      // bus idle, third port latch and edge memory start high
      st.bus_st   <= BUS_IDLE;
      st.p2_lat   <= RST_P2;
      st.p2_pin_q <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  // bus answer
  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  // pin drive and peripheral views
  assign port0_pin_out   = st.p0_out;
  assign port0_pin_oe    = st.p0_oe;
  assign port0_periph_in = st.p0_per;
  assign port1_pin_out   = st.p1_out;
  assign port1_pin_oe    = st.p1_oe;
  assign port1_periph_in = st.p1_per;
  assign port2_pin_out   = st.p2_out;
  assign port2_pin_oe    = st.p2_oe;
  assign port2_fall_edge = st.p2_edge;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pin read with a floating input bit
  pin_read_a: assert property (
      setup && st.bus_st == BUS_IDLE && paddr == OFF_P0_DATA
      && st.p0_od == 4'h0 && st.p0_dir == 4'h0
      |=> prdata[3:0] == $past(port0_pin_in) && pready)
    else $error("port0 pin read mismatch");
  // latch alias answers with the stored latch
  rmw_latch_a: assert property (
      setup && st.bus_st == BUS_IDLE && paddr == OFF_P1_LATV
      |=> prdata[7:0] == $past(st.p1_lat) && prdata[31:8] == 24'h0)
    else $error("port1 latch view mismatch");
  // controls reload while the oscillator fails
  osc_reset_a: assert property (
      osc_fail_reset |=> st.p0_dir == RST_P0 && st.p1_lat == RST_P1
      && st.p2_lat == RST_P2 && st.p0_od == RST_P0 && st.hold_en == RST_HOLD)
    else $error("osc fail did not reset controls");
  // no pin driven during oscillator failure
  osc_hiz_a: assert property (
      osc_fail_reset |=> port0_pin_oe == 4'h0
      && port1_pin_oe == 8'h00 && port2_pin_oe == 3'h0)
    else $error("pins driven during osc fail");
  // a committed write lands in the port1 latch
  latch_write_a: assert property (
      commit && pwrite && !osc_fail_reset && st.bus_st == BUS_RESP
      && (paddr == OFF_P1_DATA || paddr == OFF_P1_LATV) |=> st.p1_lat == $past(pwdata[7:0]))
    else $error("port1 latch not written");
  // latches keep their value between writes
  latch_hold_a: assert property (
      !commit && !osc_fail_reset |=> st.p0_lat == $past(st.p0_lat)
      && st.p1_lat == $past(st.p1_lat) && st.p2_lat == $past(st.p2_lat))
    else $error("latch changed without a write");
  // port0 pin drive follows the truth table
  drive_table_a: assert property (
      !osc_fail_reset && !stop_mode
      |=> port0_pin_oe == ((~st.p0_od & st.p0_dir) | (st.p0_od & ~st.p0_lat))
      && port0_pin_out == (st.p0_lat & ~st.p0_od))
    else $error("port0 drive table mismatch");
  // port1 pin drive follows the same table
  p1_table_a: assert property (
      !osc_fail_reset && !stop_mode
      |=> port1_pin_oe == ((~st.p1_od & st.p1_dir) | (st.p1_od & ~st.p1_lat))
      && port1_pin_out == (st.p1_lat & ~st.p1_od))
    else $error("port1 drive table mismatch");
  // third port pulls low only where its latch is low
  p2_drive_a: assert property (
      !osc_fail_reset && !stop_mode |=> port2_pin_oe == ~st.p2_lat && port2_pin_out == 3'h0)
    else $error("port2 drive mismatch");
  // stop without hold enable floats every port
  hold_float_a: assert property (
      stop_mode |=> st.hold_en || (port0_pin_oe == 4'h0
      && port1_pin_oe == 8'h00 && port2_pin_oe == 3'h0))
    else $error("pins driven in stop without hold");
  // stop pin floats even with hold enable
  stop_pin_a: assert property (stop_mode |=> !port2_pin_oe[0])
    else $error("stop pin driven in stop mode");
  // one pulse per falling edge of port2 pin 2
  fall_edge_a: assert property (
      st.p2_pin_q[2] && !port2_bit0_stop_pin_in[2] |=> port2_fall_edge[2] ##1 !port2_fall_edge[2])
    else $error("port2 falling edge missed");
  // peripherals see the latch of a push-pull output
  per_latch_a: assert property (
      st.p0_od == 4'h0 && st.p0_dir == 4'hF |=> port0_periph_in == $past(st.p0_lat))
    else $error("port0 peripheral view mismatch");
  // open-drain bits read the pin level
  od_read_a: assert property (
      setup && st.bus_st == BUS_IDLE && paddr == OFF_P0_DATA && st.p0_od == 4'hF
      |=> prdata[3:0] == $past(port0_pin_in))
    else $error("port0 open-drain read mismatch");
  // third port pin read, upper bits zero
  p2_upper_a: assert property (
      setup && st.bus_st == BUS_IDLE && paddr == OFF_P2_DATA
      |=> prdata[31:3] == 29'h0 && prdata[2:0] == $past(port2_bit0_stop_pin_in))
    else $error("port2 read upper bits not zero");
  // third port latch alias reads the latch
  p2_latch_a: assert property (
      setup && st.bus_st == BUS_IDLE && paddr == OFF_P2_LATV |=> prdata[2:0] == $past(st.p2_lat))
    else $error("port2 latch view mismatch");
  // zero wait states, one-cycle answer
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held for two cycles");

  rd_cover_c:   cover property (setup ##1 commit && !pwrite);
  wr_cover_c:   cover property (setup ##1 commit && pwrite && paddr == OFF_P0_DATA);
  od_low_c:     cover property (st.p1_od != 8'h00 && port1_pin_oe != 8'h00);
  osc_fail_c:   cover property (osc_fail_reset ##1 !osc_fail_reset);
  hold_stop_c:  cover property (stop_mode && st.hold_en && port2_pin_oe[2] && !port2_pin_oe[0]);

endmodule

// ### common/gpb_pkg.sv
// constants, types and helper functions for the low port bank
package gpb_pkg;

  // ----------------------------------------------------------------
  // port widths
  // ----------------------------------------------------------------
  localparam int unsigned GPB_P0_W = 4;   // 4-bit first port
  localparam int unsigned GPB_P1_W = 8;   // 8-bit second port
  localparam int unsigned GPB_P2_W = 3;   // 3-bit third port
  localparam int unsigned GPB_AW   = 8;   // apb address width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_P0_DATA = 8'h00;  // write latch, read pin view
  localparam logic [7:0] OFF_P0_LATV = 8'h04;  // write latch, read latch (rmw view)
  localparam logic [7:0] OFF_P0_DIR  = 8'h08;  // port0_direction_ctrl
  localparam logic [7:0] OFF_P0_OD   = 8'h0C;  // port0_open_drain_sel
  localparam logic [7:0] OFF_P1_DATA = 8'h10;  // write latch, read pin view
  localparam logic [7:0] OFF_P1_LATV = 8'h14;  // write latch, read latch (rmw view)
  localparam logic [7:0] OFF_P1_DIR  = 8'h18;  // port1_direction_ctrl
  localparam logic [7:0] OFF_P1_OD   = 8'h1C;  // port1_open_drain_sel
  localparam logic [7:0] OFF_P2_DATA = 8'h20;  // write latch, read pins
  localparam logic [7:0] OFF_P2_LATV = 8'h24;  // write latch, read latch (rmw view)
  localparam logic [7:0] OFF_SYSCTL  = 8'h28;  // system_control_one
  localparam logic [7:0] OFF_STATUS  = 8'h2C;  // read-only status

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_HOLD_EN  = 0;    // stop_output_hold_enable
  localparam int unsigned BIT_ST_STOP  = 0;    // status: stop mode active
  localparam int unsigned BIT_ST_OFAIL = 1;    // status: osc fail reset active
  localparam logic [3:0] RST_P0  = 4'h0;       // p0 dir, od, latch
  localparam logic [7:0] RST_P1  = 8'h00;      // p1 dir, od, latch
  localparam logic [2:0] RST_P2  = 3'h7;       // p2 latch resets to ones
  localparam logic       RST_HOLD = 1'b0;      // hold enable after reset

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,                          // waiting for setup
    BUS_RESP = 2'b10                           // access phase, pready high
  } gpb_bus_t;

  typedef struct packed {
    gpb_bus_t    bus_st;   // apb phase
    logic [31:0] prdata;   // read data
    logic        pready;   // access phase answer
    logic        pslverr;  // unmapped address
    logic [3:0]  p0_dir;   // port0 direction
    logic [3:0]  p0_od;    // port0 open drain
    logic [3:0]  p0_lat;   // port0 output latch
    logic [7:0]  p1_dir;   // port1 direction
    logic [7:0]  p1_od;    // port1 open drain
    logic [7:0]  p1_lat;   // port1 output latch
    logic [2:0]  p2_lat;   // port2 output latch
    logic        hold_en;  // outputs kept in stop mode
    logic [3:0]  p0_out;   // port0 pin drive value
    logic [3:0]  p0_oe;    // port0 pin enable
    logic [7:0]  p1_out;   // port1 pin drive value
    logic [7:0]  p1_oe;    // port1 pin enable
    logic [2:0]  p2_out;   // port2 pin drive value
    logic [2:0]  p2_oe;    // port2 pin enable
    logic [3:0]  p0_per;   // port0 peripheral input
    logic [7:0]  p1_per;   // port1 peripheral input
    logic [2:0]  p2_pin_q; // port2 pins, last cycle
    logic [2:0]  p2_edge;  // port2 falling edge pulses
  } gpb_state_t;

  // ----------------------------------------------------------------
  // truth table helpers (8 bits, narrower ports zero extend)
  // ----------------------------------------------------------------
  // read / peripheral view: latch when push-pull output, pin otherwise
  function automatic logic [7:0] gpb_view(input logic [7:0] od, input logic [7:0] dir,
                                          input logic [7:0] lat, input logic [7:0] pin);
    gpb_view = (~od & dir & lat) | ((od | ~dir) & pin);
  endfunction

  // pin enable: push-pull output, or open drain with latch low
  function automatic logic [7:0] gpb_oe(input logic [7:0] od, input logic [7:0] dir,
                                        input logic [7:0] lat);
    gpb_oe = (~od & dir) | (od & ~lat);
  endfunction

endpackage

// ### verification/gpb_pin_model.sv
// board-side model of one port's pins
`timescale 1ns/1ps
module gpb_pin_model #(
  parameter int W = 4                  // pin count
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] dev_out,   // device drive value
  input  wire logic [W-1:0] dev_oe,    // device drives when high
  input  wire logic [W-1:0] ext_en,    // board source present
  input  wire logic [W-1:0] ext_val,   // board source level
  output logic      [W-1:0] pin        // resolved pin level
);
  logic [W-1:0] flt = '0;              // undriven line level
  // undriven line toggles, so a stale level never passes for data
  always_ff @(posedge clk) begin
    flt <= ~pin;
  end
  // device wins, then a board source where ext_en is high, else floating
  always_comb begin
    pin = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | (~dev_oe & ~ext_en & flt);
  end
endmodule

// ### verification/tb_io_port_bank_low_ports.sv
// self-checking bench for the low port bank
`timescale 1ns/1ps
module tb_io_port_bank_low_ports;
  import gpb_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, osc_fail_reset = 0, stop_mode = 0;
  logic [3:0]  p0_pin, p0_out, p0_oe, p0_per, p0_en = 4'hF, p0_val = 4'h5;
  logic [7:0]  p1_pin, p1_out, p1_oe, p1_per, p1_en = 8'hFF, p1_val = 8'h5A;
  logic [2:0]  p2_pin, p2_out, p2_oe, p2_fall, acc;
  int          n_mismatch = 0, total_checks = 0;

  gpb_port_bank i_gpb_port_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_fail_reset(osc_fail_reset),
    .stop_mode(stop_mode), .port0_pin_in(p0_pin), .port0_pin_out(p0_out),
    .port0_pin_oe(p0_oe), .port0_periph_in(p0_per), .port1_pin_in(p1_pin),
    .port1_pin_out(p1_out), .port1_pin_oe(p1_oe), .port1_periph_in(p1_per),
    .port2_bit0_stop_pin_in(p2_pin), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe),
    .port2_fall_edge(p2_fall));
  gpb_pin_model #(.W(4)) i_gpb_pin_model_0 (.clk(pclk), .dev_out(p0_out),
    .dev_oe(p0_oe), .ext_en(p0_en), .ext_val(p0_val), .pin(p0_pin));
  gpb_pin_model #(.W(8)) i_gpb_pin_model_1 (.clk(pclk), .dev_out(p1_out),
    .dev_oe(p1_oe), .ext_en(p1_en), .ext_val(p1_val), .pin(p1_pin));
  // port2 lines pulled high by the board, bit0 too; outside stop mode the device pulls a line low while its latch bit is low
  gpb_pin_model #(.W(3)) i_gpb_pin_model_2 (.clk(pclk), .dev_out(p2_out),
    .dev_oe(p2_oe), .ext_en(3'h7), .ext_val(3'h7), .pin(p2_pin));

  // clock, 25 ns period
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk({7'h0, e, r}, {7'h0, xe, x});
  endtask

  // reset values and an unmapped address
  task automatic t_reset;
    rd_chk(OFF_P0_DIR, 32'h0, 1'b0);
    rd_chk(OFF_P0_LATV, 32'h0, 1'b0);
    rd_chk(OFF_P0_OD, 32'h0, 1'b0);
    rd_chk(OFF_P1_DIR, 32'h0, 1'b0);
    rd_chk(OFF_P1_LATV, 32'h0, 1'b0);
    rd_chk(OFF_P2_LATV, 32'h7, 1'b0);
    rd_chk(8'h30, 32'h0, 1'b1);
    chk({p0_oe, p1_oe, p2_oe}, 40'h0);
    $display("t_reset done");
  endtask

  // port0 through the three modes
  task automatic t_port0;
    wr(OFF_P0_LATV, 32'hA);
    rd_chk(OFF_P0_DATA, 32'h5, 1'b0);
    rd_chk(OFF_P0_LATV, 32'hA, 1'b0);
    wr(OFF_P0_DIR, 32'hF);
    @(negedge pclk);
    chk({p0_oe, p0_out}, 40'hFA);
    rd_chk(OFF_P0_DATA, 32'hA, 1'b0);
    @(negedge pclk);
    chk(p0_per, 40'hA);
    @(posedge pclk);
    p0_val <= 4'h7;
    wr(OFF_P0_OD, 32'hF);
    @(negedge pclk);
    chk(p0_oe, 40'h5);
    rd_chk(OFF_P0_DATA, 32'h2, 1'b0);
    @(negedge pclk);
    chk(p0_per, 40'h2);
    $display("t_port0 done");
  endtask

  // port1 with mixed modes per bit
  task automatic t_port1;
    wr(OFF_P1_LATV, 32'hA5);
    wr(OFF_P1_DIR, 32'hF0);
    wr(OFF_P1_OD, 32'h3C);
    @(negedge pclk);
    chk({p1_oe, p1_oe & p1_out}, 40'hD880);
    rd_chk(OFF_P1_DATA, 32'h82, 1'b0);
    @(negedge pclk);
    chk(p1_per, 40'h82);
    rd_chk(OFF_P1_LATV, 32'hA5, 1'b0);
    $display("t_port1 done");
  endtask

  // port2 driven low gives a falling edge; pin and latch views
  task automatic t_port2;
    acc = 3'h0;
    wr(OFF_P2_LATV, 32'h3);
    repeat (4) begin
      @(negedge pclk);
      acc = acc | p2_fall;
    end
    chk({acc, p2_oe, p2_out}, 40'h120);
    rd_chk(OFF_P2_DATA, 32'h3, 1'b0);
    rd_chk(OFF_P2_LATV, 32'h3, 1'b0);
    $display("t_port2 done");
  endtask

  // stop mode: bit0 of port2 floats even with hold enabled
  task automatic t_stop;
    wr(OFF_P2_LATV, 32'h2);
    wr(OFF_SYSCTL, 32'h1);
    stop_mode <= 1'b1;
    repeat (2) @(negedge pclk);
    chk({p2_oe, p0_oe}, 40'h45);
    wr(OFF_SYSCTL, 32'h0);
    @(negedge pclk);
    chk({p2_oe, p0_oe}, 40'h0);
    @(posedge pclk);
    stop_mode <= 1'b0;
    $display("t_stop done");
  endtask

  // oscillator failure floats pins and reloads controls
  task automatic t_ofail;
    wr(OFF_SYSCTL, 32'h1);
    @(posedge pclk);
    osc_fail_reset <= 1'b1;
    rd_chk(OFF_STATUS, 32'h2, 1'b0);
    @(negedge pclk);
    chk({p0_oe, p1_oe, p2_oe}, 40'h0);
    @(posedge pclk);
    osc_fail_reset <= 1'b0;
    rd_chk(OFF_P0_OD, 32'h0, 1'b0);
    rd_chk(OFF_P1_LATV, 32'h0, 1'b0);
    rd_chk(OFF_P2_LATV, 32'h7, 1'b0);
    rd_chk(OFF_SYSCTL, 32'h0, 1'b0);
    $display("t_ofail done");
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_port0();
    t_port1();
    t_port2();
    t_stop();
    t_ofail();
    summarize();
  end
endmodule
